// ===== hw/io_pin_drive_pkg.sv
package io_pin_drive_pkg;

	// ------------------------------------------------------------------
	// port geometry
	// ------------------------------------------------------------------
	localparam int NUM_PINS = 8;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int USB_HI = 7;
	localparam int USB_LO = 6;

	// ------------------------------------------------------------------
	// register byte offsets, port form
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_DM0 = 8'h00;
	localparam logic [7:0] OFS_DM1 = 8'h04;
	localparam logic [7:0] OFS_DM2 = 8'h08;
	localparam logic [7:0] OFS_OUT_DATA = 8'h0C;
	localparam logic [7:0] OFS_PIN_STATE = 8'h10;
	localparam logic [7:0] OFS_BYPASS = 8'h14;
	localparam logic [7:0] OFS_IRQ_RISE = 8'h18;
	localparam logic [7:0] OFS_IRQ_FALL = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_REGULATED = 8'h24;
	localparam logic [7:0] OFS_BIDIR = 8'h28;
	localparam logic [7:0] OFS_USB_DRV_EN = 8'h30;
	localparam logic [7:0] OFS_USB_PULLUP = 8'h34;
	localparam logic [7:0] OFS_USB_DATA = 8'h38;
	localparam logic [7:0] OFS_USB_CTRL = 8'h3C;

	// pin form: one word per pin from this base, index in bits 4:2
	localparam logic [2:0] PIN_FORM_HI = 3'h2;
	localparam int PIN_IDX_LSB = 2;
	localparam int PIN_IDX_MSB = 4;

	// ------------------------------------------------------------------
	// pin form field positions
	// ------------------------------------------------------------------
	localparam int PF_DM_LSB = 0;
	localparam int PF_DM_MSB = 2;
	localparam int PF_DATA = 3;
	localparam int PF_BYPASS = 4;
	localparam int PF_RISE = 5;
	localparam int PF_FALL = 6;
	localparam int PF_STATE = 7;
	localparam int USB_CTRL_MODE = 0;

	// ------------------------------------------------------------------
	// drive mode codes and reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] DM_RES_PULLUP = 3'h2;
	localparam logic [2:0] DM_RES_PULLDN = 3'h3;
	localparam logic [2:0] DM_OD_LOW = 3'h4;
	localparam logic [2:0] DM_OD_HIGH = 3'h5;
	localparam logic [2:0] DM_STRONG = 3'h6;
	localparam logic [2:0] DM_RES_BOTH = 3'h7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_USB = 2'h0;

	// drive state of one pin: strong enable, value, resistive pulls
	typedef struct packed {
		logic oe;
		logic out;
		logic pull_up;
		logic pull_dn;
		logic ibuf_en;
	} pin_drive_t;

	// avalon request group
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} avs_req_t;

endpackage : io_pin_drive_pkg

// ===== hw/io_pin_drive_mode_control.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
module io_pin_drive_mode_control #(
	parameter logic [7:0] RESET_DM0 = io_pin_drive_pkg::RST_BYTE,
	parameter logic [7:0] RESET_DM1 = io_pin_drive_pkg::RST_BYTE,
	parameter logic [7:0] RESET_DM2 = io_pin_drive_pkg::RST_BYTE,
	parameter logic [7:0] RESET_DATA = io_pin_drive_pkg::RST_BYTE
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire io_pin_drive_pkg::avs_req_t avs_req,
	output logic [io_pin_drive_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [io_pin_drive_pkg::NUM_PINS-1:0] pin_in,
	output io_pin_drive_pkg::pin_drive_t [io_pin_drive_pkg::NUM_PINS-1:0]
		pin_drv,
	input wire logic [io_pin_drive_pkg::NUM_PINS-1:0] periph_data,
	input wire logic [io_pin_drive_pkg::NUM_PINS-1:0] periph_oe,
	input wire logic [1:0] usb_pin_in,
	input wire logic [1:0] usb_core_out,
	input wire logic [1:0] usb_core_oe,
	output io_pin_drive_pkg::pin_drive_t [1:0] usb_pin_drv,
	output logic port_irq
);
	localparam int N = io_pin_drive_pkg::NUM_PINS;
	// ------------------------------------------------------------------
	// configuration storage
	// ------------------------------------------------------------------
	logic [N-1:0] dm0_q, dm1_q, dm2_q;
	logic [N-1:0] out_data_q;
	logic [N-1:0] bypass_q;
	logic [N-1:0] rise_q, fall_q;
	logic [N-1:0] irq_status_q;
	logic [N-1:0] regulated_q;
	logic [N-1:0] bidir_q;
	logic [1:0] usb_drv_en_q, usb_pullup_q, usb_data_q;
	logic usb_mode_q;
	// bus side
	logic wait_q;
	logic [io_pin_drive_pkg::DATA_W-1:0] rdata_q;
	logic accept;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] addr;
	logic pin_form;
	logic [2:0] pin_idx;
	logic [7:0] rd_byte;
	// pins
	logic [N-1:0] pin_meta_q, pin_sync_q, pin_prev_q;
	logic [1:0] usb_meta_q, usb_sync_q;
	logic [N-1:0] pin_state;
	logic [N-1:0] rise_evt, fall_evt, pin_evt;
	logic [N-1:0] status_clr;
	io_pin_drive_pkg::pin_drive_t [N-1:0] drv_d;
	io_pin_drive_pkg::pin_drive_t [1:0] usb_drv_d;
	io_pin_drive_pkg::pin_drive_t [N-1:0] drv_q;
	io_pin_drive_pkg::pin_drive_t [1:0] usb_drv_q;
	logic irq_q;
	// ------------------------------------------------------------------
	// avalon slave: one wait cycle, then the request is taken
	// ------------------------------------------------------------------
	assign addr = avs_req.address;
	assign accept = (avs_req.read | avs_req.write) & ~wait_q;
	assign wr_en = avs_req.write & ~wait_q & avs_req.byteenable[0];
	assign wbyte = avs_req.writedata[7:0];
	assign pin_form = addr[7:5] == io_pin_drive_pkg::PIN_FORM_HI;
	assign pin_idx = addr[io_pin_drive_pkg::PIN_IDX_MSB:
		io_pin_drive_pkg::PIN_IDX_LSB];
	// cpu and dma reach pins here
	// waitrequest rises again after each accepted request
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wait_q <= 1'b1;
		end else if (accept) begin
			wait_q <= 1'b1;
		end else if (avs_req.read | avs_req.write) begin
			wait_q <= 1'b0;
		end
	end
	// read mux, both register views from the same storage
	always_comb begin
		rd_byte = 8'h00;
		if (pin_form) begin
			rd_byte[io_pin_drive_pkg::PF_DM_MSB:io_pin_drive_pkg::PF_DM_LSB] =
				{dm2_q[pin_idx], dm1_q[pin_idx], dm0_q[pin_idx]};
			rd_byte[io_pin_drive_pkg::PF_DATA] = out_data_q[pin_idx];
			rd_byte[io_pin_drive_pkg::PF_BYPASS] = bypass_q[pin_idx];
			rd_byte[io_pin_drive_pkg::PF_RISE] = rise_q[pin_idx];
			rd_byte[io_pin_drive_pkg::PF_FALL] = fall_q[pin_idx];
			rd_byte[io_pin_drive_pkg::PF_STATE] = pin_state[pin_idx];
		end else begin
			case (addr)
				io_pin_drive_pkg::OFS_DM0: rd_byte = dm0_q;
				io_pin_drive_pkg::OFS_DM1: rd_byte = dm1_q;
				io_pin_drive_pkg::OFS_DM2: rd_byte = dm2_q;
				io_pin_drive_pkg::OFS_OUT_DATA: rd_byte = out_data_q;
				// pins read here, never the data register
				io_pin_drive_pkg::OFS_PIN_STATE: rd_byte = pin_state;
				io_pin_drive_pkg::OFS_BYPASS: rd_byte = bypass_q;
				io_pin_drive_pkg::OFS_IRQ_RISE: rd_byte = rise_q;
				io_pin_drive_pkg::OFS_IRQ_FALL: rd_byte = fall_q;
				io_pin_drive_pkg::OFS_IRQ_STATUS: rd_byte = irq_status_q;
				io_pin_drive_pkg::OFS_REGULATED: rd_byte = regulated_q;
				io_pin_drive_pkg::OFS_BIDIR: rd_byte = bidir_q;
				io_pin_drive_pkg::OFS_USB_DRV_EN:
					rd_byte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO] =
						usb_drv_en_q;
				io_pin_drive_pkg::OFS_USB_PULLUP:
					rd_byte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO] =
						usb_pullup_q;
				io_pin_drive_pkg::OFS_USB_DATA:
					rd_byte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO] =
						usb_data_q;
				io_pin_drive_pkg::OFS_USB_CTRL: begin
					rd_byte[io_pin_drive_pkg::USB_CTRL_MODE] = usb_mode_q;
					rd_byte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO] =
						usb_sync_q;
				end
				default: rd_byte = 8'h00;
			endcase
		end
	end
	// read data captured while waitrequest is still high
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (avs_req.read & wait_q) begin
			rdata_q <= {24'h000000, rd_byte};
		end
	end
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	// ------------------------------------------------------------------
	// drive mode bits, port form and pin form
	// ------------------------------------------------------------------
	// three bits per pin across three registers
	// pin form writes the same bits as port form
	// reset loads programmed state, default analog
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dm0_q <= RESET_DM0;
			dm1_q <= RESET_DM1;
			dm2_q <= RESET_DM2;
		end else if (wr_en && pin_form) begin
			dm0_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_DM_LSB];
			dm1_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_DM_LSB + 1];
			dm2_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_DM_MSB];
		end else if (wr_en) begin
			if (addr == io_pin_drive_pkg::OFS_DM0) dm0_q <= wbyte;
			if (addr == io_pin_drive_pkg::OFS_DM1) dm1_q <= wbyte;
			if (addr == io_pin_drive_pkg::OFS_DM2) dm2_q <= wbyte;
		end
	end
	// output data, bypass and edge selects, both views
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			out_data_q <= RESET_DATA;
			bypass_q <= io_pin_drive_pkg::RST_BYTE;
			rise_q <= io_pin_drive_pkg::RST_BYTE;
			fall_q <= io_pin_drive_pkg::RST_BYTE;
		end else if (wr_en && pin_form) begin
			out_data_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_DATA];
			bypass_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_BYPASS];
			rise_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_RISE];
			fall_q[pin_idx] <= wbyte[io_pin_drive_pkg::PF_FALL];
		end else if (wr_en) begin
			if (addr == io_pin_drive_pkg::OFS_OUT_DATA) out_data_q <= wbyte;
			if (addr == io_pin_drive_pkg::OFS_BYPASS) bypass_q <= wbyte;
			if (addr == io_pin_drive_pkg::OFS_IRQ_RISE) rise_q <= wbyte;
			if (addr == io_pin_drive_pkg::OFS_IRQ_FALL) fall_q <= wbyte;
		end
	end
	// regulated output and bidirectional selects, port form only
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			regulated_q <= io_pin_drive_pkg::RST_BYTE;
			bidir_q <= io_pin_drive_pkg::RST_BYTE;
		end else if (wr_en) begin
			if (addr == io_pin_drive_pkg::OFS_REGULATED) regulated_q <= wbyte;
			if (addr == io_pin_drive_pkg::OFS_BIDIR) bidir_q <= wbyte;
		end
	end

	// ------------------------------------------------------------------
	// usb-capable pin controls
	// ------------------------------------------------------------------
	// only the dedicated usb registers touch these bits
	// drive and pullup enables sit at bits 7 and 6
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			usb_drv_en_q <= io_pin_drive_pkg::RST_USB;
			usb_pullup_q <= io_pin_drive_pkg::RST_USB;
			usb_data_q <= io_pin_drive_pkg::RST_USB;
			usb_mode_q <= 1'b0;
		end else if (wr_en && !pin_form) begin
			case (addr)
				io_pin_drive_pkg::OFS_USB_DRV_EN: usb_drv_en_q <=
					wbyte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO];
				io_pin_drive_pkg::OFS_USB_PULLUP: usb_pullup_q <=
					wbyte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO];
				io_pin_drive_pkg::OFS_USB_DATA: usb_data_q <=
					wbyte[io_pin_drive_pkg::USB_HI:io_pin_drive_pkg::USB_LO];
				io_pin_drive_pkg::OFS_USB_CTRL: usb_mode_q <=
					wbyte[io_pin_drive_pkg::USB_CTRL_MODE];
				default: usb_mode_q <= usb_mode_q;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pin input sampling
	// ------------------------------------------------------------------
	// two stages before anything reads the pins
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			usb_meta_q <= '0;
			usb_sync_q <= '0;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
			usb_meta_q <= usb_pin_in;
			usb_sync_q <= usb_meta_q;
		end
	end
	// sampled level, gated by the input buffer enable
	assign pin_state = pin_sync_q & {
		dm2_q | dm1_q | dm0_q};
	// ------------------------------------------------------------------
	// edge interrupts
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= pin_state;
		end
	end
	// per pin rising, falling or both
	assign rise_evt = pin_state & ~pin_prev_q & rise_q;
	assign fall_evt = ~pin_state & pin_prev_q & fall_q;
	assign pin_evt = rise_evt | fall_evt;
	assign status_clr = (wr_en && !pin_form &&
		addr == io_pin_drive_pkg::OFS_IRQ_STATUS) ? wbyte : 8'h00;
	// event sets status; set beats a same-cycle clear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~status_clr) | pin_evt;
		end
	end
	// one request line for the whole port
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |((irq_status_q & ~status_clr) | pin_evt);
		end
	end
	assign port_irq = irq_q;
	// ------------------------------------------------------------------
	// drive decode
	// ------------------------------------------------------------------
	// table of drive states per code and data
	function automatic io_pin_drive_pkg::pin_drive_t drive_of(
		input logic [2:0] dm,
		input logic d,
		input logic regulated
	);
		io_pin_drive_pkg::pin_drive_t r;
		r = '0;
		r.ibuf_en = dm != io_pin_drive_pkg::DM_HIZ_ANALOG;
		case (dm)
			io_pin_drive_pkg::DM_RES_PULLUP: begin
				r.oe = ~d;
				r.pull_up = d & ~regulated;
			end
			io_pin_drive_pkg::DM_RES_PULLDN: begin
				r.oe = d;
				r.out = d;
				r.pull_dn = ~d & ~regulated;
			end
			io_pin_drive_pkg::DM_OD_LOW: r.oe = ~d;
			io_pin_drive_pkg::DM_OD_HIGH: begin
				r.oe = d;
				r.out = d;
			end
			io_pin_drive_pkg::DM_STRONG: begin
				r.oe = 1'b1;
				r.out = d;
			end
			io_pin_drive_pkg::DM_RES_BOTH: begin
				r.pull_up = d & ~regulated;
				r.pull_dn = ~d & ~regulated;
			end
			default: r.oe = 1'b0;
		endcase
		return r;
	endfunction : drive_of
	generate
		for (genvar i = 0; i < N; i++) begin : g_pin
			logic [2:0] dm;
			logic d;
			// routed enable low falls back to digital hi-z
			assign dm = (bidir_q[i] && !periph_oe[i]) ?
				io_pin_drive_pkg::DM_HIZ_DIGITAL :
				{dm2_q[i], dm1_q[i], dm0_q[i]};
			assign d = bypass_q[i] ? periph_data[i] : out_data_q[i];
			// regulated pins lose their resistive legs
			assign drv_d[i] = drive_of(dm, d, regulated_q[i]);
		end
		for (genvar u = 0; u < 2; u++) begin : g_usb
			always_comb begin
				usb_drv_d[u] = '0;
				usb_drv_d[u].ibuf_en = 1'b1;
				if (usb_mode_q) begin
					// usb mode ignores the i/o controls
					usb_drv_d[u].oe = usb_core_oe[u];
					usb_drv_d[u].out = usb_core_out[u];
				end else if (usb_drv_en_q[u]) begin
					// strong both ways whatever the pullup
					usb_drv_d[u].oe = 1'b1;
					usb_drv_d[u].out = usb_data_q[u];
				end else begin
					usb_drv_d[u].oe = ~usb_data_q[u];
					usb_drv_d[u].pull_up = usb_data_q[u] & usb_pullup_q[u];
				end
			end
		end
	endgenerate
	// registered pad controls; gpio and usb pads alike held all-off (hi-z) while in reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			drv_q <= '0;
			usb_drv_q <= '0;
		end else begin
			drv_q <= drv_d;
			usb_drv_q <= usb_drv_d;
		end
	end
	assign pin_drv = drv_q;
	assign usb_pin_drv = usb_drv_q;
endmodule : io_pin_drive_mode_control

// ===== testbench/io_pin_drive_sva.sv
module io_pin_drive_sva (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire io_pin_drive_pkg::avs_req_t avs_req,
	input wire logic [io_pin_drive_pkg::DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [io_pin_drive_pkg::NUM_PINS-1:0] pin_in,
	input wire io_pin_drive_pkg::pin_drive_t [io_pin_drive_pkg::NUM_PINS-1:0]
		pin_drv,
	input wire logic [io_pin_drive_pkg::NUM_PINS-1:0] periph_data,
	input wire logic [io_pin_drive_pkg::NUM_PINS-1:0] periph_oe,
	input wire io_pin_drive_pkg::pin_drive_t [1:0] usb_pin_drv,
	input wire logic port_irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	logic acc;
	logic [2:0] since_chg_q;
	logic [2:0] quiet_q;
	logic [7:0] oe_v, pu_v, pd_v, ib_v;
	logic [1:0] uoe_v, upu_v, upd_v;
	assign acc = (avs_req.read || avs_req.write) && !avs_waitrequest;
	// flatten pad controls so one relation covers every pin
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			oe_v[i] = pin_drv[i].oe;
			pu_v[i] = pin_drv[i].pull_up;
			pd_v[i] = pin_drv[i].pull_dn;
			ib_v[i] = pin_drv[i].ibuf_en;
		end
		for (int k = 0; k < 2; k++) begin
			uoe_v[k] = usb_pin_drv[k].oe;
			upu_v[k] = usb_pin_drv[k].pull_up;
			upd_v[k] = usb_pin_drv[k].pull_dn;
		end
	end
	// cycles since the pin levels last moved, saturating
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			since_chg_q <= 3'h7;
		else if ($changed(pin_in))
			since_chg_q <= 3'h0;
		else if (since_chg_q != 3'h7)
			since_chg_q <= since_chg_q + 3'h1;
	end
	// cycles since a bus access or a peripheral input change
	always_ff @(posedge ref_clk) begin
		if (!nrst || acc || $changed(periph_data) || $changed(periph_oe))
			quiet_q <= 3'h0;
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	end
	sequence s_req_new;
		$rose(avs_req.read || avs_req.write);
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_wait_first: assert property (s_req_new |-> s_one_wait)
		else $error("wait state count wrong");
	a_wait_rearm: assert property (acc |=> avs_waitrequest)
		else $error("waitrequest not raised after access");
	a_read_upper: assert property (
		acc && avs_req.read |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_no_fight: assert property ((oe_v & (pu_v | pd_v)) == 8'h00)
		else $error("strong and resistive leg together");
	a_pull_excl: assert property ((pu_v & pd_v) == 8'h00)
		else $error("both resistive legs on");
	a_ibuf_gate: assert property (
		((oe_v | pu_v | pd_v) & ~ib_v) == 8'h00)
		else $error("driven pin with input buffer off");
	a_irq_edge: assert property (
		$rose(port_irq) |-> since_chg_q <= 3'h4)
		else $error("interrupt without a recent pin edge");
	a_irq_clear: assert property (
		$fell(port_irq) |-> $past(acc) || $past(acc, 2))
		else $error("interrupt dropped without a bus write");
	a_drv_cause: assert property (
		$changed(pin_drv) |-> quiet_q <= 3'h3)
		else $error("pad drive moved without a cause");
	a_usb_pull: assert property (((uoe_v & upu_v) | upd_v) == 2'h0)
		else $error("usb pad resistive leg wrong");
endmodule : io_pin_drive_sva

bind io_pin_drive_mode_control io_pin_drive_sva u_sva (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.avs_req(avs_req),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.pin_in(pin_in),
	.pin_drv(pin_drv),
	.periph_data(periph_data),
	.periph_oe(periph_oe),
	.usb_pin_drv(usb_pin_drv),
	.port_irq(port_irq)
);

// ===== testbench/pin_load_model.sv
module pin_load_model (
	input wire logic ref_clk,
	input wire io_pin_drive_pkg::pin_drive_t [7:0] pin_drv,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	logic flip_q = 1'b0;
	// a floating pin wanders, so a stale level can never pass for a read
	always_ff @(posedge ref_clk) begin
		flip_q <= ~flip_q;
	end
	// strong leg wins, then the outside source, then the 5k legs
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_drv[i].oe)
				pin_lvl[i] = pin_drv[i].out;
			else if (ext_en[i])
				pin_lvl[i] = ext_val[i];
			else if (pin_drv[i].pull_up || pin_drv[i].pull_dn)
				pin_lvl[i] = pin_drv[i].pull_up;
			else
				pin_lvl[i] = flip_q ^ i[0];
		end
	end
endmodule : pin_load_model

// ===== testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] RST_OFS [16] = '{8'h00, 8'h04, 8'h08, 8'h0C,
		8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34,
		8'h38, 8'h3C, 8'h2C};
	localparam logic [7:0] OUT_PAT = 8'hA5;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	io_pin_drive_pkg::avs_req_t avs_req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] pin_in, v;
	logic [7:0] periph_data = 8'h00, periph_oe = 8'h00;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
	logic [1:0] usb_pin_in = 2'h0, usb_core_out = 2'h0, usb_core_oe = 2'h0;
	io_pin_drive_pkg::pin_drive_t [7:0] pin_drv;
	io_pin_drive_pkg::pin_drive_t [1:0] usb_pin_drv;
	logic port_irq;
	int n_fail = 0, tests_run = 0, seed = 54308;
	logic [31:0] exp_q [$];

	// -----------------------------------------------------------------
	// clock, design and pin load
	// -----------------------------------------------------------------
	always #5 ref_clk = ~ref_clk;
	io_pin_drive_mode_control u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_in(pin_in), .pin_drv(pin_drv), .periph_data(periph_data),
		.periph_oe(periph_oe), .usb_pin_in(usb_pin_in),
		.usb_core_out(usb_core_out), .usb_core_oe(usb_core_oe),
		.usb_pin_drv(usb_pin_drv), .port_irq(port_irq));
	pin_load_model u_load (.ref_clk(ref_clk), .pin_drv(pin_drv),
		.ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// expected {ibuf, oe, driven value, pull up, pull down}
	function automatic logic [4:0] exp_drv(input logic [2:0] m,
		input logic d, input logic r);
		case (m)
			3'h0: return 5'h00;
			3'h1: return 5'h10;
			3'h2: return d ? {3'h4, ~r, 1'b0} : 5'h18;
			3'h3: return d ? 5'h1C : {4'h8, ~r};
			3'h4: return d ? 5'h10 : 5'h18;
			3'h5: return d ? 5'h1C : 5'h10;
			3'h6: return d ? 5'h1C : 5'h18;
			default: return {3'h4, d & ~r, ~d & ~r};
		endcase
	endfunction : exp_drv
	function automatic logic [4:0] obs(input io_pin_drive_pkg::pin_drive_t p);
		return {p.ibuf_en, p.oe, p.oe & p.out, p.pull_up, p.pull_dn};
	endfunction : obs
	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : check
	// hold the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_req.address <= a;
		avs_req.read <= ~wr;
		avs_req.write <= wr;
		avs_req.writedata <= d;
		avs_req.byteenable <= 4'hF;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h000000, d});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(1'b0, a, 32'h00000000);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// each answered read retires the oldest noted expectation
	always @(posedge ref_clk) begin
		if (avs_req.read && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0)
				check("unexpected read", 32'h0, 32'h1);
			else
				check("readdata", exp_q.pop_front(), avs_readdata);
		end
	end
	// long stop in case the bus never answers
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		tick(1);
		// pads start in analog hi-z, registers cleared
		for (int i = 0; i < 8; i++)
			check("reset pad", 5'h00, obs(pin_drv[i]));
		// usb enables clear, data 0: open drain pulls the pad low
		check("reset usb", 5'h18, obs(usb_pin_drv[0]));
		check("reset irq", 1'b0, port_irq);
		foreach (RST_OFS[j])
			rd(RST_OFS[j], 8'h00);
		wr(8'h2C, 8'hFF);
		rd(8'h2C, 8'h00);
		wr(io_pin_drive_pkg::OFS_OUT_DATA, OUT_PAT);
		for (int r = 0; r < 2; r++) begin
			wr(io_pin_drive_pkg::OFS_REGULATED, {8{r[0]}});
			for (int m = 0; m < 8; m++) begin
				wr(io_pin_drive_pkg::OFS_DM0, {8{m[0]}});
				wr(io_pin_drive_pkg::OFS_DM1, {8{m[1]}});
				wr(io_pin_drive_pkg::OFS_DM2, {8{m[2]}});
				tick(1);
				for (int i = 0; i < 8; i++)
					check("mode drive", exp_drv(m[2:0], OUT_PAT[i], r[0]),
						obs(pin_drv[i]));
				rd(io_pin_drive_pkg::OFS_DM2, {8{m[2]}});
			end
		end
		// bypass data and routed enable, strong mode
		wr(io_pin_drive_pkg::OFS_REGULATED, 8'h00);
		wr(io_pin_drive_pkg::OFS_BYPASS, 8'h0F);
		wr(io_pin_drive_pkg::OFS_BIDIR, 8'hC0);
		wr(io_pin_drive_pkg::OFS_DM0, 8'h00);
		repeat (4) begin
			@(posedge ref_clk);
			periph_data <= 8'($random(seed));
			periph_oe <= 8'($random(seed));
			tick(1);
			for (int i = 0; i < 8; i++)
				check("bypass drive", exp_drv((i > 5 && !periph_oe[i]) ?
					3'h1 : 3'h6, i < 4 ? periph_data[i] : OUT_PAT[i],
					1'b0), obs(pin_drv[i]));
		end
		// pin form writes seen through the port form
		for (int i = 0; i < 8; i++)
			wr(8'h40 + 8'(4 * i), {4'h0, i[0], i[2:0]});
		rd(io_pin_drive_pkg::OFS_DM0, 8'hAA);
		rd(io_pin_drive_pkg::OFS_DM1, 8'hCC);
		rd(io_pin_drive_pkg::OFS_DM2, 8'hF0);
		rd(io_pin_drive_pkg::OFS_BYPASS, 8'h00);
		// pin state writes leave output data alone
		wr(io_pin_drive_pkg::OFS_DM0, 8'hFF);
		wr(io_pin_drive_pkg::OFS_DM1, 8'h00);
		wr(io_pin_drive_pkg::OFS_DM2, 8'h00);
		v = 8'($random(seed));
		@(posedge ref_clk);
		ext_en <= 8'hFF;
		ext_val <= v;
		tick(3);
		rd(io_pin_drive_pkg::OFS_PIN_STATE, v);
		wr(io_pin_drive_pkg::OFS_PIN_STATE, ~v);
		rd(io_pin_drive_pkg::OFS_OUT_DATA, 8'hAA);
		rd(io_pin_drive_pkg::OFS_PIN_STATE, v);
		rd(8'h48, {v[2], 7'h01});
		@(posedge ref_clk);
		ext_val <= 8'h00;
		tick(3);
		wr(io_pin_drive_pkg::OFS_IRQ_RISE, 8'h05);
		wr(io_pin_drive_pkg::OFS_IRQ_FALL, 8'h06);
		wr(io_pin_drive_pkg::OFS_IRQ_STATUS, 8'hFF);
		tick(2);
		check("irq idle", 1'b0, port_irq);
		for (int e = 0; e < 2; e++) begin
			@(posedge ref_clk);
			ext_val <= e == 0 ? 8'h0F : 8'h00;
			tick(4);
			check("irq raised", 1'b1, port_irq);
			rd(io_pin_drive_pkg::OFS_IRQ_STATUS, e == 0 ? 8'h05 : 8'h06);
			wr(io_pin_drive_pkg::OFS_IRQ_STATUS, 8'h02);
			rd(io_pin_drive_pkg::OFS_IRQ_STATUS, e == 0 ? 8'h05 : 8'h04);
			wr(io_pin_drive_pkg::OFS_IRQ_STATUS, 8'hFF);
			tick(2);
			check("irq cleared", 1'b0, port_irq);
		end
		// usb drive and pull-up enable combinations
		for (int c = 0; c < 8; c++) begin
			wr(io_pin_drive_pkg::OFS_USB_PULLUP, {{2{c[2]}}, 6'h00});
			wr(io_pin_drive_pkg::OFS_USB_DRV_EN, {{2{c[1]}}, 6'h00});
			wr(io_pin_drive_pkg::OFS_USB_DATA, {{2{c[0]}}, 6'h00});
			tick(1);
			for (int k = 0; k < 2; k++)
				check("usb drive", c[1] ? {2'h1, c[0], 2'h0} :
					c[0] ? {3'h0, c[2], 1'b0} : 5'h08,
					obs(usb_pin_drv[k]) & 5'h0F);
		end
		// port-wide writes leave the usb enables alone
		wr(io_pin_drive_pkg::OFS_DM0, 8'h00);
		tick(1);
		check("usb kept", 5'h0C, obs(usb_pin_drv[1]) & 5'h0F);
		rd(io_pin_drive_pkg::OFS_USB_DRV_EN, 8'hC0);
		// usb mode hands the pads to the core
		@(posedge ref_clk);
		usb_core_oe <= 2'h1;
		usb_core_out <= 2'h3;
		usb_pin_in <= 2'h2;
		wr(io_pin_drive_pkg::OFS_USB_CTRL, 8'h01);
		tick(1);
		check("usb core 0", 5'h0C, obs(usb_pin_drv[0]) & 5'h0F);
		check("usb core 1", 5'h00, obs(usb_pin_drv[1]) & 5'h0F);
		rd(io_pin_drive_pkg::OFS_USB_CTRL, 8'h81);
		tick(2);
		check("reads left", 32'h0, exp_q.size());
		tally_and_finish();
	end
endmodule : testbench
